// ===== design/dmarr_channel_mux.sv
`timescale 1ns/1ps
`default_nettype none
// Selects one channel's request and gates its acknowledge pin.
module dmarr_channel_mux (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [2:0] source_sel,
   input wire logic ack_mask,
   input wire logic external_req,
   input wire logic periph_a_req,
   input wire logic periph_b_req,
   input wire logic periph_c_req,
   input wire logic timer_out,
   input wire logic ack_from_dma_n,
   output logic request_to_dma,
   output logic channel_ack_pin_n,
   output logic channel_ack_oe
);
   logic [1:0] ext_sync_reg;
   logic timer_prev_reg;
   logic req_next;

   // Only the pin is asynchronous; the other sources share aclk.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_sync_reg <= 2'h0;
         timer_prev_reg <= 1'b0;
      end else begin
         ext_sync_reg <= {ext_sync_reg[0], external_req};
         timer_prev_reg <= timer_out;
      end
   end

   // Source decode; reserved codes give no request.
   always_comb begin
      // [R1] [R12] selector decode
      unique case (source_sel)
         dmarr_pkg::SRC_EXTERNAL: req_next = ext_sync_reg[1];
         // [R9] [R10] peripheral sources
         dmarr_pkg::SRC_PERIPH_A: req_next = periph_a_req;
         dmarr_pkg::SRC_PERIPH_B: req_next = periph_b_req;
         dmarr_pkg::SRC_PERIPH_C: req_next = periph_c_req;
         // [R6] timer pulse edge
         dmarr_pkg::SRC_TIMER: req_next = timer_out & ~timer_prev_reg;
         default: req_next = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         request_to_dma <= 1'b0;
      end else begin
         request_to_dma <= req_next;
      end
   end

   // [R2] [R3] pin-only acknowledge gate
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         channel_ack_pin_n <= 1'b1;
         channel_ack_oe <= 1'b0;
      end else begin
         channel_ack_pin_n <= ack_from_dma_n | ack_mask;
         channel_ack_oe <= ~ack_mask;
      end
   end
endmodule // dmarr_channel_mux
`default_nettype wire

// ===== design/dmarr_pkg.sv
// Notes on behaviour
// [R1] Each channel has a 3-bit request selector.
// [R2] Per-channel bit gates acknowledge at pin.
// [R3] Acknowledge never routed to on-chip peripherals.
// [R4] External masters cannot reach internal peripherals.
// [R5] Peripheral moves use device addresses, two cycles.
// [R6] Selected timer pulses each trigger a transfer.
// [R7] Channel 1 external use excludes serial 1.
// [R8] Bit 7 masks channel 1 acknowledge pin.
// [R9] Channel 1 field bits 6-4 source codes.
// [R10] Channel 0 field bits 2-0 source codes.
// [R11] Bit 3 masks channel 0 acknowledge pin.
// [R12] 000 external, 100 timer, 101-111 reserved.
package dmarr_pkg;
   localparam logic [15:0] CFG_OFFSET = 16'hf830;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam int CH1_MASK_BIT = 7;
   localparam int CH1_SRC_LSB = 4;
   localparam int CH0_MASK_BIT = 3;
   localparam int CH0_SRC_LSB = 0;
   localparam int SRC_WIDTH = 3;
   localparam logic [2:0] SRC_EXTERNAL = 3'h0;
   localparam logic [2:0] SRC_PERIPH_A = 3'h1;
   localparam logic [2:0] SRC_PERIPH_B = 3'h2;
   localparam logic [2:0] SRC_PERIPH_C = 3'h3;
   localparam logic [2:0] SRC_TIMER = 3'h4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== design/dmarr_top.sv
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// DMA request routing with AXI4-Lite configuration.
// ************************************************************
module dmarr_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [15:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [15:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic external_request_ch0,
   input wire logic external_request_ch1,
   input wire logic serial0_receive_buffer_full,
   input wire logic serial1_receive_buffer_full,
   input wire logic serial0_transmit_buffer_empty,
   input wire logic serial1_transmit_buffer_empty,
   input wire logic sync_serial_rx_full,
   input wire logic sync_serial_tx_empty,
   input wire logic timer1_output,
   input wire logic timer2_output,
   input wire logic dma_ack0_n,
   input wire logic dma_ack1_n,
   output logic dma_request0,
   output logic dma_request1,
   output logic channel0_ack_pin_n,
   output logic channel0_ack_oe,
   output logic channel1_ack_pin_n,
   output logic channel1_ack_oe,
   output logic [2:0] ch0_request_source,
   output logic [2:0] ch1_request_source
);
   logic [7:0] cfg_reg;
   logic aw_have_reg, w_have_reg;
   logic [15:0] awaddr_reg;
   logic [7:0] wdata_reg;
   logic wstrb0_reg;

   function automatic logic hits_cfg(input logic [15:0] a);
      hits_cfg = (a[15:2] == dmarr_pkg::CFG_OFFSET[15:2]);
   endfunction

   // Write channels are held until both halves are in, then one response.
   assign s_axi_awready = ~aw_have_reg & ~s_axi_bvalid;
   assign s_axi_wready = ~w_have_reg & ~s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         awaddr_reg <= 16'h0;
         wdata_reg <= 8'h0;
         wstrb0_reg <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= dmarr_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            wdata_reg <= s_axi_wdata[7:0];
            wstrb0_reg <= s_axi_wstrb[0];
         end
         if (aw_have_reg && w_have_reg) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= hits_cfg(awaddr_reg) ? dmarr_pkg::RESP_OKAY
                                                : dmarr_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Configuration register; only byte lane 0 carries the 8 bits.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_reg <= dmarr_pkg::CFG_RESET;
      end else if (aw_have_reg && w_have_reg && hits_cfg(awaddr_reg) && wstrb0_reg) begin
         cfg_reg <= wdata_reg;
      end
   end

   // Reads answer one cycle after the address is taken.
   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= dmarr_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= hits_cfg(s_axi_araddr) ? {24'h0, cfg_reg} : 32'h0;
         s_axi_rresp <= hits_cfg(s_axi_araddr) ? dmarr_pkg::RESP_OKAY
                                               : dmarr_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // [R5] DMA-side addressing only
   // Requests are only routed here; the controller makes every address, so a
   // peripheral move is always its two-cycle transaction, never a flyby.
   // Current selectors shown as state outputs.
   assign ch0_request_source = cfg_reg[dmarr_pkg::CH0_SRC_LSB +: dmarr_pkg::SRC_WIDTH];
   assign ch1_request_source = cfg_reg[dmarr_pkg::CH1_SRC_LSB +: dmarr_pkg::SRC_WIDTH];

   // [R10] [R11] channel 0 routing
   dmarr_channel_mux u_ch0 (
      .aclk(aclk),
      .aresetn(aresetn),
      .source_sel(ch0_request_source),
      .ack_mask(cfg_reg[dmarr_pkg::CH0_MASK_BIT]),
      .external_req(external_request_ch0),
      .periph_a_req(serial0_receive_buffer_full),
      .periph_b_req(serial1_transmit_buffer_empty),
      .periph_c_req(sync_serial_tx_empty),
      .timer_out(timer1_output),
      .ack_from_dma_n(dma_ack0_n),
      .request_to_dma(dma_request0),
      .channel_ack_pin_n(channel0_ack_pin_n),
      .channel_ack_oe(channel0_ack_oe)
   );

   // [R8] [R9] channel 1 routing
   dmarr_channel_mux u_ch1 (
      .aclk(aclk),
      .aresetn(aresetn),
      .source_sel(ch1_request_source),
      .ack_mask(cfg_reg[dmarr_pkg::CH1_MASK_BIT]),
      .external_req(external_request_ch1),
      .periph_a_req(serial1_receive_buffer_full),
      .periph_b_req(serial0_transmit_buffer_empty),
      .periph_c_req(sync_serial_rx_full),
      .timer_out(timer2_output),
      .ack_from_dma_n(dma_ack1_n),
      .request_to_dma(dma_request1),
      .channel_ack_pin_n(channel1_ack_pin_n),
      .channel_ack_oe(channel1_ack_oe)
   );

   // ************************************************************
   // Checks on routing and the bus answer.
   // ************************************************************

   // [R8] mask check
   AST_CH1_MASK: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
      cfg_reg[7] |=> channel1_ack_pin_n) else $error("ch1 ack not masked");
   // [R11] mask check
   AST_CH0_MASK: assert property (@(posedge aclk) disable iff (!aresetn) // [R11]
      cfg_reg[3] |=> channel0_ack_pin_n) else $error("ch0 ack not masked");
   // [R12] reserved code
   AST_RSV0: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
      ch0_request_source[2] && ch0_request_source[1:0] != 2'h0 |=> !dma_request0)
      else $error("reserved ch0 code requested");
   // [R12] reserved code
   AST_RSV1: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
      ch1_request_source[2] && ch1_request_source[1:0] != 2'h0 |=> !dma_request1)
      else $error("reserved ch1 code requested");
   // [R6] timer pulse
   AST_TMR1: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
      ch1_request_source == 3'h4 && $rose(timer2_output) |=> dma_request1)
      else $error("timer pulse lost");
   // [R6] timer pulse
   AST_TMR0: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
      ch0_request_source == 3'h4 && $rose(timer1_output) |=> dma_request0)
      else $error("ch0 timer pulse lost");
   // [R9] peripheral source
   AST_SRC1: assert property (@(posedge aclk) disable iff (!aresetn) // [R9]
      ch1_request_source == 3'h1 |=> dma_request1 == $past(serial1_receive_buffer_full))
      else $error("ch1 source wrong");
   // [R9] peripheral source
   AST_SRC1_TBE: assert property (@(posedge aclk) disable iff (!aresetn) // [R9]
      ch1_request_source == 3'h2 |=> dma_request1 == $past(serial0_transmit_buffer_empty))
      else $error("ch1 transmit source wrong");
   // [R10] peripheral source
   AST_SRC0: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
      ch0_request_source == 3'h3 |=> dma_request0 == $past(sync_serial_tx_empty))
      else $error("ch0 source wrong");
   // [R10] peripheral source
   AST_SRC0_RBF: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
      ch0_request_source == 3'h1 |=> dma_request0 == $past(serial0_receive_buffer_full))
      else $error("ch0 receive source wrong");
   // [R1] external path
   AST_EXT0: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
      ch0_request_source == 3'h0 && external_request_ch0 ##1 external_request_ch0
      && ch0_request_source == 3'h0 ##1 ch0_request_source == 3'h0 |=> dma_request0)
      else $error("external request lost");
   // [R2] enable follows
   AST_OE1: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
      !cfg_reg[7] |=> channel1_ack_oe) else $error("ch1 ack not driven");
   // [R2] enable follows
   AST_OE0: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
      !cfg_reg[3] |=> channel0_ack_oe) else $error("ch0 ack not driven");
   // A response must stand until the master takes it.
   AST_BVALID_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write response dropped");
   AST_RVALID_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("read response dropped");
endmodule // dmarr_top
`default_nettype wire

// ===== testbench/dmarr_dma_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stands in for both DMA channels, acknowledging a request one cycle later.
module dmarr_dma_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic request0,
   input wire logic request1,
   output logic ack0_n,
   output logic ack1_n
);
   // pin acks only
   // Answers by its acknowledge lines alone and never addresses peripherals.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ack0_n <= 1'b1;
         ack1_n <= 1'b1;
      end else begin
         ack0_n <= !request0;
         ack1_n <= !request1;
      end
   end
endmodule // dmarr_dma_model
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [15:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic dma_ack0_n, dma_ack1_n, dma_request0, dma_request1;
   logic channel0_ack_pin_n, channel0_ack_oe, channel1_ack_pin_n, channel1_ack_oe;
   logic [2:0] ch0_request_source, ch1_request_source;
   logic [9:0] src;
   int errors, check_count, cnt;
   // Rows: configuration, source levels, expected requests {ch1, ch0}.
   logic [7:0] rc [12] = '{8'h00, 8'h11, 8'h11, 8'h22, 8'h22, 8'h33, 8'h33, 8'h55, 8'h77,
      8'h88, 8'h66, 8'h44};
   logic [9:0] rs [12] = '{10'h003, 10'h00c, 10'h0f3, 10'h030, 10'h0cf, 10'h040, 10'h080,
      10'h0ff, 10'h3ff, 10'h003, 10'h0ff, 10'h300};
   logic [1:0] rq [12] = '{2'h3, 2'h3, 2'h0, 2'h3, 2'h0, 2'h2, 2'h1, 2'h0, 2'h0, 2'h3, 2'h0, 2'h0};
   dmarr_top dmarr_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_request_ch0(src[0]),
      .external_request_ch1(src[1]), .serial0_receive_buffer_full(src[2]),
      .serial1_receive_buffer_full(src[3]), .serial0_transmit_buffer_empty(src[4]),
      .serial1_transmit_buffer_empty(src[5]), .sync_serial_rx_full(src[6]),
      .sync_serial_tx_empty(src[7]), .timer1_output(src[8]), .timer2_output(src[9]),
      .dma_ack0_n, .dma_ack1_n, .dma_request0, .dma_request1, .channel0_ack_pin_n,
      .channel0_ack_oe, .channel1_ack_pin_n, .channel1_ack_oe, .ch0_request_source,
      .ch1_request_source);
   dmarr_dma_model dmarr_dma_model_i (.aclk, .aresetn, .request0(dma_request0),
      .request1(dma_request1), .ack0_n(dma_ack0_n), .ack1_n(dma_ack1_n));
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   task chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %0t got %h expected %h", $time, s, e);
      end
   endtask
   task stop_test;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // A bus answer that never arrives ends the run as a mismatch.
   task tmo(input int n);
      if (n >= 40) begin
         errors++;
         stop_test();
      end
   endtask
   // Handshakes are judged on values settled before the edge, so the
   // combinational ready is never read after it has already dropped.
   task wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      logic aw_ok, w_ok, b_ok;
      n = 0;
      b_ok = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge aclk);
         aw_ok = s_axi_awvalid && s_axi_awready;
         w_ok = s_axi_wvalid && s_axi_wready;
         b_ok = s_axi_bvalid;
         if (b_ok) rsp = s_axi_bresp;
         @(posedge aclk);
         n++;
         if (aw_ok) s_axi_awvalid <= 1'b0;
         if (w_ok) s_axi_wvalid <= 1'b0;
      end while (!b_ok && n < 40);
      tmo(b_ok ? 0 : 40);
      s_axi_bready <= 1'b0;
   endtask
   task rdr(input logic [15:0] a);
      int n;
      logic ar_ok, r_ok;
      n = 0;
      r_ok = 1'b0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge aclk);
         ar_ok = s_axi_arvalid && s_axi_arready;
         r_ok = s_axi_rvalid;
         if (r_ok) begin
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
         end
         @(posedge aclk);
         n++;
         if (ar_ok) s_axi_arvalid <= 1'b0;
      end while (!r_ok && n < 40);
      tmo(r_ok ? 0 : 40);
      s_axi_rready <= 1'b0;
   endtask
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, src} = '0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rdr(16'hf830);
      chk(rd, 32'h0);
      chk(32'({channel1_ack_pin_n, channel0_ack_pin_n, dma_request1, dma_request0}), 32'hc);
      $display("reset test done");
      // Each row settles for six cycles, covering pin sync and the acknowledge loop.
      for (int i = 0; i < 12; i++) begin
         src <= rs[i];
         wr(16'hf830, 32'(rc[i]), 4'hf);
         repeat (6) @(posedge aclk);
         chk(32'({dma_request1, dma_request0}), 32'(rq[i]));
         chk(32'({channel1_ack_pin_n, channel0_ack_pin_n}), 2'(~rq[i] | {rc[i][7], rc[i][3]}));
         chk(32'({channel1_ack_oe, channel0_ack_oe}), 2'(~{rc[i][7], rc[i][3]}));
         chk(32'({ch1_request_source, ch0_request_source}), 32'({rc[i][6:4], rc[i][2:0]}));
         rdr(16'hf830);
         chk(rd, 32'(rc[i]));
         $display("row %0d done", i);
      end
      src <= '0;
      wr(16'hf830, 32'h44, 4'hf);
      repeat (4) @(posedge aclk);
      cnt = 0;
      for (int k = 0; k < 24; k++) begin
         @(posedge aclk);
         src[9:8] <= (k % 8 < 2) ? 2'h3 : 2'h0;
         cnt += int'(dma_request0) + int'(dma_request1);
      end
      chk(32'(cnt), 32'd6);
      $display("timer test done");
      wr(16'hf834, 32'h5, 4'hf);
      chk(32'(rsp), 32'(dmarr_pkg::RESP_SLVERR));
      rdr(16'hf834);
      chk(rd, 32'h0);
      chk(32'(rsp), 32'(dmarr_pkg::RESP_SLVERR));
      wr(16'hf830, 32'hff, 4'h0);
      chk(32'(rsp), 32'(dmarr_pkg::RESP_OKAY));
      rdr(16'hf830);
      chk(rd, 32'h44);
      $display("bus test done");
      wr(16'hf830, 32'hff, 4'hf);
      @(posedge aclk);
      aresetn <= 1'b0;
      @(posedge aclk);
      aresetn <= 1'b1;
      rdr(16'hf830);
      chk(rd, 32'h0);
      chk(32'({channel1_ack_oe, channel0_ack_oe}), 32'h3);
      $display("second reset test done");
      stop_test();
   end
endmodule // testbench
`default_nettype wire
